// [rtl/ecb_ctrl_one.sv]
/*
 * Control register 1 of echo canceller B, with the steering levels it
 * drives into the signal path. Assumes a plain register port on clk_sys
 * and a synchronous active-low reset; the signal path lies outside.
 */
`timescale 1ns/1ps
`default_nettype none

module ecb_ctrl_one
    import ecb_pkg::*;
(
    input wire logic clk_sys,
    input wire logic rst_b,
    input wire logic [`ECB_ADDR_W-1:0] reg_addr,
    input wire logic [`ECB_DATA_W-1:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [`ECB_DATA_W-1:0] reg_rdata,
    output logic back_to_back_mode,
    output logic noise_inject_off,
    output logic rx_pad_on,
    output logic path_bypass,
    output logic coef_clear,
    output logic adapt_enable,
    output ecb_mode_t mode
);

    // All state of the block.
    typedef struct packed {
        ecb_ctrl_t ctrl;
        logic [`ECB_DATA_W-1:0] rdata;
        logic coef_clear;
        logic adapt_enable;
        ecb_mode_t mode;
    } ecb_state_t;

    ecb_state_t st;
    ecb_state_t next_st;
    ecb_ctrl_t next_ctrl;
    ecb_ctrl_t reset_ctrl;
    logic [`ECB_DATA_W-1:0] reset_word;
    logic init_req;
    logic dec_clear;
    logic dec_adapt;
    ecb_mode_t dec_mode;
    logic hit;

    // Reset image of the stored fields, bit 7 dropped.
    // The power-up word is cut on purpose: bit 7 is never stored.
    assign reset_word = `ECB_CTRL1_RESET;
    assign reset_ctrl = reset_word[`ECB_BIT_NOISE_OFF:`ECB_BIT_RSV0];
    assign hit = (reg_addr == `ECB_CTRL1_ADDR);
    assign init_req = reg_wr & hit & reg_wdata[`ECB_BIT_INIT];

    // The decoder sees the value being written so decoded outputs change at the same edge as the stored fields.
    ecb_mode_decode u_decode (
        .ctrl(next_ctrl),
        .init_req(init_req),
        .coef_clear(dec_clear),
        .adapt_enable(dec_adapt),
        .mode(dec_mode)
    );

    // Register write, read and self-clearing initialisation.
    always_comb begin
        next_ctrl = st.ctrl;
        if (init_req) begin
            next_ctrl = reset_ctrl;
        end else if (reg_wr && hit) begin
            // Reserved bits are stored as written; software keeps 1 and 0 there.
            next_ctrl = ecb_ctrl_t'(reg_wdata[`ECB_BIT_NOISE_OFF:`ECB_BIT_RSV0]);
        end
        next_st = st;
        next_st.ctrl = next_ctrl;
        next_st.coef_clear = dec_clear;
        next_st.adapt_enable = dec_adapt;
        next_st.mode = dec_mode;
        // Bit 7 always reads 0 because initialisation completes in one cycle.
        if (reg_rd && hit) begin
            next_st.rdata = {1'b0, st.ctrl};
        end else begin
            next_st.rdata = `ECB_UNMAPPED_READ;
        end
    end

    // Single state register with synchronous reset: fields to the power-up value, coef_clear set and adapt_enable cleared.
    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            next_st_reset_apply: begin
                st.ctrl <= reset_ctrl;
                st.rdata <= `ECB_UNMAPPED_READ;
                st.coef_clear <= 1'b1;
                st.adapt_enable <= 1'b0;
                st.mode <= ECB_MODE_ADAPT;
            end
        end else begin
            st <= next_st;
        end
    end

    // Outputs come straight from the state register.
    assign reg_rdata = st.rdata;
    assign back_to_back_mode = st.ctrl.back_to_back_mode;
    assign noise_inject_off = st.ctrl.noise_inject_off;
    assign rx_pad_on = st.ctrl.pad;
    assign path_bypass = st.ctrl.bypass;
    assign coef_clear = st.coef_clear;
    assign adapt_enable = st.adapt_enable;
    assign mode = st.mode;

endmodule // ecb_ctrl_one

`default_nettype wire

// [pkg/ecb_defines.svh]
/*
 * Register offset, field positions and reset value of the canceller B
 * first control register, and the control-port widths.
 * Assumes inclusion by bare name from the design files.
 */
`ifndef ECB_DEFINES_SVH
`define ECB_DEFINES_SVH

`define ECB_ADDR_W 8
`define ECB_DATA_W 8
`define ECB_CTRL1_ADDR 8'h20
`define ECB_CTRL1_RESET 8'h02
`define ECB_BIT_INIT 7
`define ECB_BIT_NOISE_OFF 6
`define ECB_BIT_B2B 5
`define ECB_BIT_PAD 4
`define ECB_BIT_BYPASS 3
`define ECB_BIT_FREEZE 2
`define ECB_BIT_RSV1 1
`define ECB_BIT_RSV0 0
`define ECB_UNMAPPED_READ 8'h00

`endif

// [pkg/ecb_pkg.sv]
/*
 * Types shared by the canceller B control register bank.
 * Assumes the defines header supplies widths.
 */
`include "ecb_defines.svh"

package ecb_pkg;

    // Decoded control fields; bit 7 is not stored since it self-clears.
    typedef struct packed {
        logic noise_inject_off;
        logic back_to_back_mode;
        logic pad;
        logic bypass;
        logic adapt_freeze;
        logic rsv1;
        logic rsv0;
    } ecb_ctrl_t;

    // Mode of the canceller as seen by the signal path.
    typedef enum logic [1:0] {
        ECB_MODE_ADAPT,
        ECB_MODE_FROZEN,
        ECB_MODE_BYPASS
    } ecb_mode_t;

endpackage : ecb_pkg

// [rtl/ecb_mode_decode.sv]
/*
 * Decodes the stored control fields into the steering levels that the
 * signal path uses. Purely combinational; the top registers its outputs.
 */
`timescale 1ns/1ps
`default_nettype none

module ecb_mode_decode
    import ecb_pkg::*;
(
    input wire ecb_ctrl_t ctrl,
    input wire logic init_req,
    output logic coef_clear,
    output logic adapt_enable,
    output ecb_mode_t mode
);

    // Bypass dominates freeze, because bypass also zeroes the coefficients.
    always_comb begin
        coef_clear = ctrl.bypass | init_req;
        adapt_enable = ~ctrl.bypass & ~ctrl.adapt_freeze & ~init_req;
        if (ctrl.bypass) begin
            mode = ECB_MODE_BYPASS;
        end else if (ctrl.adapt_freeze) begin
            mode = ECB_MODE_FROZEN;
        end else begin
            mode = ECB_MODE_ADAPT;
        end
    end

endmodule // ecb_mode_decode

`default_nettype wire

// [verification/ecb_ctrl_one_checker.sv]
/* Port assertions of ecb_ctrl_one; assumes a bind. */
`timescale 1ns/1ps
`default_nettype none
module ecb_ctrl_one_checker
(
    input wire logic clk_sys,
    input wire logic rst_b,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic back_to_back_mode,
    input wire logic noise_inject_off,
    input wire logic path_bypass,
    input wire logic coef_clear,
    input wire logic adapt_enable
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!rst_b);
    wire logic m = reg_wr && reg_addr == 8'h20;
    wire logic w = m && !reg_wdata[7];
    property p_bb; w |=> back_to_back_mode == $past(reg_wdata[5]); endproperty
    a_bb: assert property (p_bb) else $error("bb");
    property p_ni; w |=> noise_inject_off == $past(reg_wdata[6]); endproperty
    a_ni: assert property (p_ni) else $error("ni");
    property p_by; w |=> path_bypass == $past(reg_wdata[3]); endproperty
    a_by: assert property (p_by) else $error("by");
    property p_zc; path_bypass |-> coef_clear && !adapt_enable; endproperty
    a_zc: assert property (p_zc) else $error("zc");
    property p_fz;
        w && !reg_wdata[3] |=> adapt_enable == !$past(reg_wdata[2]) && !coef_clear;
    endproperty
    a_fz: assert property (p_fz) else $error("fz");
    property p_in; m && reg_wdata[7] |=> coef_clear && !path_bypass; endproperty
    a_in: assert property (p_in) else $error("in");
    c_in: cover property (m && reg_wdata[7]);
    c_by: cover property (path_bypass);
    c_fz: cover property (w && reg_wdata[2]);
endmodule // ecb_ctrl_one_checker
`default_nettype wire

// [verification/testbench.sv]
/* Register bench; assumes the checker. */
`timescale 1ns/1ps
`default_nettype none
module testbench;
    logic clk_sys = 0, rst_b = 0, reg_wr = 0, reg_rd = 0;
    logic [7:0] reg_addr = 0, reg_wdata = 0, reg_rdata;
    logic back_to_back_mode, noise_inject_off, rx_pad_on, path_bypass, coef_clear, adapt_enable;
    logic [1:0] mode;
    int miscompares = 0, n_checks = 0;
    always #12.5 clk_sys = ~clk_sys;
    ecb_ctrl_one u_ecb_ctrl_one (.*);
    // One compare task for every kind of result.
    task automatic chk(string name, logic [7:0] exp, logic [7:0] got);
        n_checks++;
        if (got !== exp) begin
            $display("mismatch %s %h %h", name, exp, got);
            miscompares++;
        end
    endtask
    // Strobe for one cycle; the slave takes it at the next edge.
    task automatic acc(logic w, logic [7:0] a, d);
        @(posedge clk_sys);
        {reg_wr, reg_rd, reg_addr, reg_wdata} <= {w, !w, a, d};
        @(posedge clk_sys);
        {reg_wr, reg_rd} <= 2'b00;
        #1;
        if (!w) chk("rdata", d, reg_rdata);
    endtask
    // Field outputs after writes, including bypass, freeze and initialisation.
    task automatic t_outputs;
        acc(1, 8'h20, 8'h22);
        chk("b2b", 1, back_to_back_mode);
        chk("adapt", 1, adapt_enable);
        chk("mode", ecb_pkg::ECB_MODE_ADAPT, mode);
        acc(1, 8'h20, 8'h0A);
        chk("bypass", 1, path_bypass);
        chk("clear", 1, coef_clear);
        chk("adapt", 0, adapt_enable);
        chk("mode", ecb_pkg::ECB_MODE_BYPASS, mode);
        acc(1, 8'h20, 8'h06);
        chk("adapt", 0, adapt_enable);
        chk("clear", 0, coef_clear);
        chk("mode", ecb_pkg::ECB_MODE_FROZEN, mode);
        acc(1, 8'h20, 8'h52);
        chk("noise", 1, noise_inject_off);
        chk("pad", 1, rx_pad_on);
        acc(1, 8'h20, 8'h80);
        chk("clear", 1, coef_clear);
        chk("noise", 0, noise_inject_off);
        @(posedge clk_sys);
        #1 chk("clear", 0, coef_clear);
        chk("adapt", 1, adapt_enable);
    endtask
    task automatic t_fields;
        acc(0, 8'h20, 8'h02);
        for (int b = 2; b < 7; b++) begin
            acc(1, 8'h20, 8'h02 | 8'h01 << b);
            acc(0, 8'h20, 8'h02 | 8'h01 << b);
        end
    endtask
    task automatic t_init;
        acc(1, 8'h20, 8'hFF);
        acc(1, 8'h21, 8'h7C);
        acc(0, 8'h20, 8'h02);
        acc(0, 8'h21, 8'h00);
    endtask
    task automatic complete_run;
        $display("checks %0d miscompares %0d", n_checks, miscompares);
        if (miscompares == 0 && n_checks > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    initial begin
        #10us;
        miscompares++;
        complete_run;
    end
    initial begin
        repeat (15) @(posedge clk_sys);
        #1 chk("clear", 1, coef_clear);
        chk("adapt", 0, adapt_enable);
        @(posedge clk_sys);
        rst_b <= 1;
        t_fields;
        t_outputs;
        t_init;
        complete_run;
    end
endmodule // testbench
bind ecb_ctrl_one ecb_ctrl_one_checker u_ecb_ctrl_one_checker (.*);
`default_nettype wire
